// ### rtl/serial_mode_pkg.sv
// Constants, field layout and carrier structs for the serial port mode block.
// Assumes one 100 MHz clock domain and an AXI4-Lite master for software access.
package serial_mode_pkg;

   // Mode word: one bit per power-of-two mode code
   localparam int MODE_W      = 14;
   localparam int B_QUIET     = 0;   // code 1
   localparam int B_COMPUTER  = 1;   // code 2
   localparam int B_PW_GATE   = 2;   // code 4
   localparam int B_HW_HS     = 3;   // code 8
   localparam int B_HESSEN    = 4;   // code 16
   localparam int B_MULTIDROP = 5;   // code 32
   localparam int B_MODEM     = 6;   // code 64
   localparam int B_FIXUP     = 7;   // code 128
   localparam int B_XON_OFF   = 8;   // code 256, set disables XON/XOFF
   localparam int B_QUEUE     = 9;   // code 512, set disables char queue
   localparam int B_RS485     = 10;  // code 1024, second port only
   localparam int B_E71       = 11;  // code 2048
   localparam int B_PROMPT    = 12;  // code 4096
   localparam int B_E81       = 13;  // code 8192
   localparam logic [MODE_W-1:0] MODE_RESET = 14'h0380;

   // Register map (byte addresses)
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_MODE_P1 = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_MODE_P2 = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h08;

   // Status register fields, four bits per port, then RS-485 state
   localparam int ST_PORT_W = 4;
   localparam int ST_RS485  = 8;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // User side of one port, same clock as the block
   typedef struct packed {
      logic char_busy;    // A character is on the wire
      logic cmd_valid;    // A decoded command is offered
      logic cmd_help;     // That command is the help request
      logic pw_ok;        // Correct password seen, pulse
      logic logout;       // End of session, pulse
      logic modem_ack;    // Modem start-up string sent, pulse
      logic unsolicited;  // Port wants to send a warning
      logic requested;    // That warning was asked for
      logic rx_room;      // Receiver can take more characters
   } port_in_s;

   typedef struct packed {
      logic parity_en;
      logic seven_bits;
      logic echo_en;
      logic msg_en;
      logic cmd_accept;
      logic hessen;
      logic fixup_en;
      logic xon_xoff_en;
      logic queue_en;
      logic prompt_en;
      logic multidrop_en;
      logic rs485_en;
      logic tx_hold;
      logic rts_n;
      logic dtr_n;
      logic logged_in;
      logic modem_init_req;
   } port_out_s;

endpackage

// ### rtl/sync_two_stage.sv
// Two flip-flop synchroniser for asynchronous pin levels.
// Assumes the inputs change slowly compared with the clock.
`timescale 1ns/1ps
module sync_two_stage #(
   parameter int          W        = 1,
   parameter logic [W-1:0] INIT    = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_s;

   sync_s st;
   sync_s next_st;

   // First stage is read only by the second
   always_comb begin
      next_st.meta   = d;
      next_st.stable = st.meta;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= {INIT, INIT};
      end else begin
         st <= next_st;
      end
   end

   assign q = st.stable;

endmodule // sync_two_stage

// ### rtl/port_mode.sv
// Per-port mode decode: framing, echo, message gate, password gate, modem.
// Assumes a mode word held elsewhere and a synchronised CTS level.
`timescale 1ns/1ps
module port_mode
   import serial_mode_pkg::*;
#(
   parameter bit SECOND = 1'b0
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // Mode word and link levels
   input  wire logic [MODE_W-1:0] mode,
   input  wire logic              cts_ok,
   // User side
   input  wire port_in_s          pin,
   output port_out_s              pout
);

   typedef struct packed {
      logic parity_en;
      logic seven_bits;
      logic logged_in;
      logic modem_pend;
      logic modem_was;
   } pm_s;

   pm_s st;
   pm_s next_st;

   always_comb begin
      next_st = st;
      // Framing only changes between characters
      if (!pin.char_busy) begin
         next_st.parity_en  = mode[B_E81] | mode[B_E71];
         next_st.seven_bits = mode[B_E71];
      end
      // Login: set wins over logout
      if (pin.logout)
         next_st.logged_in = 1'b0;
      if (pin.pw_ok)
         next_st.logged_in = 1'b1;
      // Modem start-up string owed on enable or power-up
      next_st.modem_was = mode[B_MODEM];
      if (pin.modem_ack)
         next_st.modem_pend = 1'b0;
      if (mode[B_MODEM] && !st.modem_was)
         next_st.modem_pend = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs decoded from the registered mode word
   always_comb begin
      pout.parity_en    = st.parity_en;
      pout.seven_bits   = st.seven_bits;
      pout.echo_en      = ~mode[B_COMPUTER];
      pout.msg_en       = pin.unsolicited &
                          (~mode[B_QUIET] | pin.requested);
      pout.cmd_accept   = pin.cmd_valid & (~mode[B_PW_GATE] |
                          st.logged_in | pin.cmd_help);
      pout.hessen       = mode[B_HESSEN];
      pout.fixup_en     = mode[B_FIXUP];
      pout.xon_xoff_en  = ~mode[B_XON_OFF];
      pout.queue_en     = ~mode[B_QUEUE];
      pout.prompt_en    = mode[B_PROMPT] & ~mode[B_COMPUTER];
      pout.rs485_en     = SECOND & mode[B_RS485];
      pout.multidrop_en = mode[B_MULTIDROP] & ~pout.rs485_en;
      pout.tx_hold      = mode[B_HW_HS] & ~cts_ok;
      pout.rts_n        = mode[B_HW_HS] & ~pin.rx_room;
      pout.dtr_n        = ~mode[B_MODEM];
      pout.logged_in    = st.logged_in;
      pout.modem_init_req = st.modem_pend;
   end

endmodule // port_mode

// ### rtl/serial_mode_cfg.sv
// Mode configuration for two serial ports, reached over AXI4-Lite.
// Assumes a single 100 MHz clock, CTS pins arriving asynchronously and
// user-side port logic on the same clock.
//
// Behaviour
// - Each mode is one power-of-two bit, and the mode word reads back as the sum of codes.
// - Quiet mode blocks unsolicited messages unless the remote party asked for them.
// - Computer mode turns off echo of received characters.
// - Framing defaults to no parity, 8 bits, 1 stop; code 8192 selects even parity, 8 bits.
// - Code 2048 selects even parity, 7 data bits, 1 stop bit.
// - Code 1024 puts the second port into RS-485, which overrides multidrop.
// - With the password gate on, only the help request is accepted before login.
// - Code 32 enables multidrop, with commands addressed by instrument identifier.
// - Code 64 requests a modem start-up string and drives the modem control line.
// - Code 128 enables parity fix-up for the Hessen protocol and is on by default.
// - Code 256 disables XON/XOFF flow control and is set by default.
// - Code 8 enables RTS/CTS flow control, holding transmission while CTS is off.
// - Code 512 disables the character queue and is set by default.
// - Code 4096 enables a command prompt in terminal mode.
// - Code 16 selects the Hessen command protocol.
// - Each port has its own mode word, independent of the other.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module serial_mode_cfg
   import serial_mode_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Clear-to-send pins, active low, asynchronous
   input  wire logic              first_cts_n,
   input  wire logic              second_cts_n,
   // First serial port user side
   input  wire port_in_s          first_serial_port_in,
   output port_out_s              first_serial_port_out,
   // Second serial port user side
   input  wire port_in_s          second_serial_port_in,
   output port_out_s              second_serial_port_out
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic              aw_got;
      logic [ADDR_W-1:0] waddr;
      logic              w_got;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic [MODE_W-1:0] mode_p1;
      logic [MODE_W-1:0] mode_p2;
   } cfg_s;

   cfg_s st;
   cfg_s next_st;

   logic [1:0] cts_n_sync;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Merge a write into a mode word by byte lane; upper bits are dropped
   function automatic logic [MODE_W-1:0] merge_mode(
      input logic [MODE_W-1:0] old_w,
      input logic [31:0]       data,
      input logic [3:0]        strb
   );
      logic [MODE_W-1:0] res;
      res = old_w;
      if (strb[0])
         res[7:0] = data[7:0];
      if (strb[1])
         res[MODE_W-1:8] = data[MODE_W-1:8];
      return res;
   endfunction

   // Known register offsets
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (a == OFF_MODE_P1) || (a == OFF_MODE_P2) || (a == OFF_STATUS);
   endfunction

   // Four status bits of one port
   function automatic logic [ST_PORT_W-1:0] port_status(input port_out_s p);
      return {p.modem_init_req, p.logged_in, p.seven_bits, p.parity_en};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus handshakes

   // Address and data are held off while a response is pending
   assign s_axi_awready = ~st.aw_got & ~st.bvalid;
   assign s_axi_wready  = ~st.w_got & ~st.bvalid;
   assign s_axi_arready = ~st.rvalid;

   // Response outputs straight from flip-flops
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp  = st.bresp;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp  = st.rresp;
   assign s_axi_rdata  = st.rdata;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [31:0] rd;
      rd      = '0;
      next_st = st;

      // Capture write address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_got = 1'b1;
         next_st.waddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end

      // Retire write response
      if (st.bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;

      // Perform write once both halves are held
      if (st.aw_got && st.w_got) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = mapped(st.waddr) ? RESP_OKAY : RESP_SLVERR;
         // Each port keeps its own word
         if (st.waddr == OFF_MODE_P1)
            next_st.mode_p1 = merge_mode(st.mode_p1, st.wdata, st.wstrb);
         if (st.waddr == OFF_MODE_P2)
            next_st.mode_p2 = merge_mode(st.mode_p2, st.wdata, st.wstrb);
      end

      // Retire read response
      if (st.rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;

      // Read: mode words read back as the combined mode code
      if (s_axi_arvalid && s_axi_arready) begin
         case (s_axi_araddr)
            OFF_MODE_P1: rd[MODE_W-1:0] = st.mode_p1;
            OFF_MODE_P2: rd[MODE_W-1:0] = st.mode_p2;
            OFF_STATUS: begin
               rd[ST_PORT_W-1:0]           = port_status(first_serial_port_out);
               rd[2*ST_PORT_W-1:ST_PORT_W] = port_status(second_serial_port_out);
               rd[ST_RS485]                = second_serial_port_out.rs485_en;
            end
            default: rd = '0;
         endcase
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd;
         next_st.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // Defaults leave XON/XOFF, queue and fix-up bits set
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st         <= '0;
         st.mode_p1 <= MODE_RESET;
         st.mode_p2 <= MODE_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins into the clock domain

   // CTS idles inactive (high) so hardware flow control starts held off
   sync_two_stage #(
      .W    (2),
      .INIT (2'h3)
   ) u_cts_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      ({second_cts_n, first_cts_n}),
      .q      (cts_n_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Port decode, one instance per port

   port_mode #(
      .SECOND (1'b0)
   ) u_first_port (
      .clk    (clk),
      .resetn (resetn),
      .mode   (st.mode_p1),
      .cts_ok (~cts_n_sync[0]),
      .pin    (first_serial_port_in),
      .pout   (first_serial_port_out)
   );

   // Only this port can switch to RS-485
   port_mode #(
      .SECOND (1'b1)
   ) u_second_port (
      .clk    (clk),
      .resetn (resetn),
      .mode   (st.mode_p2),
      .cts_ok (~cts_n_sync[1]),
      .pin    (second_serial_port_in),
      .pout   (second_serial_port_out)
   );

endmodule // serial_mode_cfg

// ### test/serial_mode_cfg_checker.sv
// Assertions on the user-side ports of the serial mode block.
// Assumes one clock domain and an active-low synchronous reset.
`timescale 1ns/1ps
module serial_mode_cfg_checker
   import serial_mode_pkg::*;
(
   // Clock and reset
   input wire logic      clk,
   input wire logic      resetn,
   // Pins and user sides
   input wire logic      first_cts_n,
   input wire port_in_s  first_serial_port_in,
   input wire port_out_s first_serial_port_out,
   input wire port_in_s  second_serial_port_in,
   input wire port_out_s second_serial_port_out
);
   // Short aliases keep the properties readable
   wire port_in_s  i1 = first_serial_port_in;
   wire port_out_s o1 = first_serial_port_out;
   wire port_out_s o2 = second_serial_port_out;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////
   // Framing only moves between characters; a reset edge may clear it
   a_frame_frozen: assert property (
      $past(resetn) && $past(i1.char_busy) |-> $stable({o1.parity_en, o1.seven_bits}))
      else $error("framing changed mid character");
   a_seven_parity: assert property (o1.seven_bits |-> o1.parity_en)
      else $error("seven bits without even parity");
   a_rs485_first: assert property (o2.rs485_en |-> !o2.multidrop_en)
      else $error("multidrop beside RS-485");
   a_quiet_gate: assert property (o1.msg_en |-> i1.unsolicited)
      else $error("message without a cause");
   a_help_open: assert property (i1.cmd_valid && i1.cmd_help |-> o1.cmd_accept)
      else $error("help request refused");
   a_login_cause: assert property ($rose(o1.logged_in) |-> $past(i1.pw_ok))
      else $error("login without password");
   // Pending start-up string only clears on its acknowledge
   a_modem_clear: assert property (
      $fell(o1.modem_init_req) && $past(resetn) |-> $past(i1.modem_ack))
      else $error("modem request dropped");
   a_modem_line: assert property ($rose(o1.modem_init_req) |-> !o1.dtr_n)
      else $error("modem line not asserted");
   // Two synchroniser stages lie between the pin and the hold
   a_cts_hold: assert property (
      o1.tx_hold && $past(resetn) && $past(resetn, 2) |-> $past(first_cts_n, 2))
      else $error("hold without inactive handshake");
   a_rts_room: assert property (o1.rts_n |-> !i1.rx_room)
      else $error("handshake dropped with room");
endmodule // serial_mode_cfg_checker

// ### test/remote_party.sv
// Remote computer on the first port: sends characters, drives its handshake.
// Assumes the bench requests a character with a one-cycle pulse.
`timescale 1ns/1ps
module remote_party #(
   parameter int BIT_CYC = 4
) (
   // Clock
   input  wire logic clk,
   // Bench requests
   input  wire logic send,
   input  wire logic stall,
   // Framing in force
   input  wire logic parity_en,
   input  wire logic seven_bits,
   // Line state
   output logic      char_busy,
   output logic      cts_n
);
   int left = 0;
   ////////////////////////////////////////
   // Frame length is start, data, optional parity and stop, matched to the device
   always @(posedge clk) begin
      if (send && left == 0)
         left <= BIT_CYC * (10 - seven_bits + parity_en);
      else if (left != 0)
         left <= left - 1;
      cts_n <= stall; // inactive while we cannot take data
   end
   assign char_busy = (left != 0);
endmodule // remote_party

// ### test/serial_mode_cfg_test.sv
// Self-checking bench for the serial mode block.
// Assumes the remote party model and the checker are compiled first.
`timescale 1ns/1ps
module serial_mode_cfg_test
   import serial_mode_pkg::*;
;
   logic              clk = 1'b0, resetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0]       wdata = '0, rdata;
   logic [1:0]        bresp, rresp;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid = 1'b0, rready = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid;
   logic              cts1_n, cts2_n = 1'b0, send = 1'b0, stall = 1'b0, busy;
   port_in_s          i1v = 9'h001, i2v = 9'h001, i1; // Receiver has room
   port_out_s         o1, o2;
   int                failures = 0, tests_run = 0;
   ////////////////////////////////////////
   always #5 clk = ~clk;
   // Character activity of the remote party joins the first port's inputs
   always_comb begin
      i1 = i1v;
      i1.char_busy = busy;
   end
   serial_mode_cfg DUT (.clk(clk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .first_cts_n(cts1_n), .second_cts_n(cts2_n),
      .first_serial_port_in(i1), .first_serial_port_out(o1),
      .second_serial_port_in(i2v), .second_serial_port_out(o2));
   remote_party #(.BIT_CYC(4)) remote (.clk(clk), .send(send), .stall(stall),
      .parity_en(o1.parity_en), .seven_bits(o1.seven_bits), .char_busy(busy), .cts_n(cts1_n));
   ////////////////////////////////////////
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Write: both halves offered together, each released once taken
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      bready <= 1'b0;
      chk({n < 50, bresp}, {1'b1, er});
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      rready <= 1'b0;
      chk({n < 50, rresp, rdata}, {1'b1, er, ed});
   endtask
   ////////////////////////////////////////
   task automatic t_reset;
      rd(OFF_MODE_P1, 32'h80 + 32'h100 + 32'h200, RESP_OKAY); // reset word
      rd(OFF_MODE_P2, 32'h80 + 32'h100 + 32'h200, RESP_OKAY); // own word
      chk({o1.fixup_en, o1.xon_xoff_en, o1.queue_en}, 3'b100); // defaults
      chk({o1.parity_en, o1.seven_bits, o2.parity_en}, 3'b000); // plain framing
   endtask
   task automatic t_sum;
      wr(OFF_MODE_P1, 32'h1 + 32'h2 + 32'h20, RESP_OKAY);
      rd(OFF_MODE_P1, 32'h23, RESP_OKAY); // sum of codes
      i1v.unsolicited <= 1'b1;
      tick(2);
      chk({o1.echo_en, o1.multidrop_en, o1.msg_en}, 3'b010); // no echo, quiet
      i1v.requested <= 1'b1;
      tick(2);
      chk(o1.msg_en, 1'b1); // asked
      i1v.unsolicited <= 1'b0;
      i1v.requested <= 1'b0;
   endtask
   // Every code alone on the second port, then width and unmapped places
   task automatic t_each;
      for (int i = 0; i < MODE_W; i++) begin
         wr(OFF_MODE_P2, 32'h1 << i, RESP_OKAY);
         rd(OFF_MODE_P2, 32'h1 << i, RESP_OKAY); // one code
      end
      rd(OFF_MODE_P1, 32'h23, RESP_OKAY); // other port kept
      wr(OFF_MODE_P1, 32'hffff_ffff, RESP_OKAY);
      rd(OFF_MODE_P1, 32'h3fff, RESP_OKAY); // fourteen bits
      wr(8'h0c, 32'h1, RESP_SLVERR); // unmapped
      rd(8'h0c, 32'h0, RESP_SLVERR); // unmapped
   endtask
   task automatic t_frame;
      wr(OFF_MODE_P1, 32'h0, RESP_OKAY);
      tick(2);
      send <= 1'b1;
      tick(1);
      send <= 1'b0;
      wr(OFF_MODE_P1, 32'h2000, RESP_OKAY);
      tick(2);
      chk({busy, o1.parity_en}, 2'b10); // held mid character
      for (int n = 0; n < 100 && busy; n++) @(posedge clk);
      tick(3);
      chk({o1.parity_en, o1.seven_bits}, 2'b10); // even, eight bits
      wr(OFF_MODE_P1, 32'h800, RESP_OKAY);
      tick(3);
      chk({o1.parity_en, o1.seven_bits}, 2'b11); // even, seven bits
   endtask
   task automatic t_485;
      wr(OFF_MODE_P2, 32'h400 + 32'h20, RESP_OKAY);
      wr(OFF_MODE_P1, 32'h400 + 32'h20, RESP_OKAY);
      tick(1);
      chk({o2.rs485_en, o2.multidrop_en, o1.rs485_en, o1.multidrop_en}, 4'b1001);
      // Both start-up strings still owed, plain framing, second port on RS-485
      rd(OFF_STATUS, 32'h188, RESP_OKAY); // status word
   endtask
   task automatic t_gate;
      wr(OFF_MODE_P1, 32'h4, RESP_OKAY);
      i1v.cmd_valid <= 1'b1;
      i1v.cmd_help  <= 1'b1;
      tick(2);
      chk(o1.cmd_accept, 1'b1); // help passes
      i1v.cmd_help <= 1'b0;
      tick(2);
      chk(o1.cmd_accept, 1'b0); // locked
      i1v.pw_ok <= 1'b1;
      tick(1);
      i1v.pw_ok <= 1'b0;
      tick(2);
      chk({o1.logged_in, o1.cmd_accept}, 2'b11); // after password
      i1v.logout <= 1'b1;
      tick(1);
      i1v.logout    <= 1'b0;
      i1v.cmd_valid <= 1'b0;
      tick(2);
      chk(o1.logged_in, 1'b0); // session over
   endtask
   task automatic t_modem;
      for (int k = 0; k < 2; k++) begin
         wr(OFF_MODE_P1, k ? 32'h40 : 32'h0, RESP_OKAY);
         tick(1);
         if (k) chk({o1.modem_init_req, o1.dtr_n}, 2'b10); // string due, line on
         i1v.modem_ack <= 1'b1;
         tick(1);
         i1v.modem_ack <= 1'b0;
         tick(1);
         chk(o1.modem_init_req, 1'b0); // cleared by ack
      end
   endtask
   task automatic t_hs;
      wr(OFF_MODE_P1, 32'h8, RESP_OKAY);
      stall  <= 1'b1;
      cts2_n <= 1'b1;
      tick(5);
      chk({o1.tx_hold, o2.tx_hold}, 2'b10); // remote not ready, other port free
      stall  <= 1'b0;
      cts2_n <= 1'b0;
      i1v.rx_room <= 1'b0;
      tick(5);
      chk({o1.tx_hold, o1.rts_n}, 2'b01); // we hold off the remote
      i1v.rx_room <= 1'b1;
   endtask
   task automatic t_misc;
      wr(OFF_MODE_P1, 32'h10, RESP_OKAY);
      tick(1);
      chk(o1.hessen, 1'b1); // protocol chosen
      for (int k = 0; k < 2; k++) begin
         wr(OFF_MODE_P1, k ? 32'h1002 : 32'h1000, RESP_OKAY);
         tick(1);
         chk(o1.prompt_en, k ? 1'b0 : 1'b1); // terminal only
      end
   endtask
   ////////////////////////////////////////
   task automatic tally_and_finish;
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence
   initial begin
      tick(12);
      resetn <= 1'b1;
      tick(3);
      t_reset();
      t_sum();
      t_each();
      t_frame();
      t_485();
      t_gate();
      t_modem();
      t_hs();
      t_misc();
      tally_and_finish();
   end
   // Watchdog, far beyond the expected run
   initial begin
      #100000;
      failures++;
      tally_and_finish();
   end
endmodule // serial_mode_cfg_test
bind serial_mode_cfg serial_mode_cfg_checker chk_i (.clk(clk), .resetn(resetn),
   .first_cts_n(first_cts_n),
   .first_serial_port_in(first_serial_port_in),
   .first_serial_port_out(first_serial_port_out),
   .second_serial_port_in(second_serial_port_in),
   .second_serial_port_out(second_serial_port_out));
